// ### rtl/mie_core.sv
// Instruction decode and execute unit of the 8-bit core with an APB status port
// Overview of operation
// RULE_01: Thirty-seven instructions, each one 16-bit word from program memory.
// RULE_02: Immediate add into accumulator sets carry, nibble carry, zero; one cycle.
// RULE_03: Relative jump: counter plus one plus signed accumulator; two cycles, flags kept.
// RULE_04: Destination bit zero writes accumulator, one writes the memory byte.
// RULE_05: Memory plus accumulator, stored per destination, sets three flags, one cycle.
// RULE_06: Same add including carry in, three flags, one cycle.
// RULE_07: AND, OR, XOR literal and memory forms change only zero; one cycle.
// RULE_08: Bit clear and set force bit 0-7 of a byte, no flags.
// RULE_09: Bit tests skip next on low or high; one or two cycles, no flags.
// RULE_10: Call pushes counter plus one; jumps and returns take two cycles.
// RULE_11: Increment and decrement skip on zero result, store per destination, no flags.
// RULE_12: Plain increment, decrement, invert, clear change only zero; one cycle.
// RULE_13: Subtractions set carry as not-borrow, nibble carry and zero; one cycle.
// RULE_14: Watchdog kick clears the counter in one cycle, arithmetic flags kept.
// RULE_15: Memory operands address bytes 00h to 7Fh.
// RULE_16: After halt the counter stays until an interrupt arrives.
// RULE_17: After sleep oscillators stop until external interrupt or reset; power-down updated.
// RULE_18: Rotates go through carry, store per destination, set carry and zero.
// RULE_19: Moves and no-operation take one cycle and change no flags.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module mie_core
	import mie_pkg::*;
#(
	parameter int unsigned WDT_LIMIT = WDT_LIMIT_DEF
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Program memory
	output logic      [PC_W-1:0]   prog_addr,
	input  wire logic [15:0]       prog_data,
	// Wake and power
	input  wire logic              irq_ext,
	output logic                   osc_stop
);
	// ====================
	// Helpers
	function automatic mie_alu_s add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [4:0] lo;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		return '{c: full[8], dc: lo[4], sum: full[7:0]};
	endfunction

	function automatic logic [7:0] bitmask(input logic [2:0] b);
		return 8'h01 << b;
	endfunction

	// ====================
	// State
	mie_state_e      st_reg;
	mie_flags_s      flg_reg, flg_next;
	logic [PC_W-1:0] pc_reg, pc_next, push_pc, rel_tgt;
	logic [7:0]      w_reg, res, fval, k;
	logic [15:0]     wdt_reg;
	logic [2:0]      ctrl_reg, sp_reg;
	logic [6:0]      maddr_reg, fa;
	logic            gie_reg;
	logic [7:0]      mem [MEM_D];
	logic [PC_W-1:0] stk [STACK_D];
	mie_op_e         op;
	mie_alu_s        alu;
	logic            is_jump, dsel, wr_w, wr_f, dst, two, skip, push, pop, gie_set;
	logic            kick, go_halt, go_sleep, set_cdz, set_z, set_c, new_c;
	logic            run, irq_pend, take_irq, timeout, exec_ok;
	logic [2:0]      bsel;

	assign run       = ctrl_reg[CTRL_RUN];
	assign irq_pend  = irq_ext | ctrl_reg[CTRL_SIRQ];
	assign timeout   = ctrl_reg[CTRL_WDTEN] && wdt_reg == 16'(WDT_LIMIT - 1);
	assign take_irq  = gie_reg && irq_pend;
	assign exec_ok   = st_reg == ST_EXEC && run && !take_irq && !timeout;
	assign prog_addr = pc_reg;
	assign osc_stop  = st_reg == ST_SLEEP; // [RULE_17]

	// ====================
	// Decode
	assign is_jump = prog_data[15:12] == JUMP_PFX; // [RULE_01]
	assign op      = mie_op_e'(prog_data[15:10]);
	assign k       = prog_data[7:0];
	assign dsel    = prog_data[7];
	assign fa      = prog_data[6:0]; // [RULE_15]
	assign bsel    = prog_data[9:7];
	assign fval    = mem[fa];
	assign rel_tgt = pc_reg + 11'h001 + {{3{w_reg[7]}}, w_reg}; // [RULE_03]

	always_comb begin
		res = fval;
		alu = '0;
		pc_next = pc_reg + 11'h001;
		push_pc = pc_reg + 11'h001; // [RULE_10]
		{wr_w, wr_f, dst, two, skip, push, pop, gie_set} = '0;
		{kick, go_halt, go_sleep, set_cdz, set_z, set_c, new_c} = '0;
		if (is_jump) begin
			pc_next = prog_data[10:0]; // [RULE_10]
			two = 1'b1;
			push = prog_data[JUMP_CALL_BIT];
		end else begin
			unique case (op)
				SUM_IMMEDIATE_INTO_ACCUMULATOR: begin
					alu = add8(w_reg, k, 1'b0); // [RULE_02]
					wr_w = 1'b1;
					set_cdz = 1'b1;
				end
				RELATIVE_JUMP_BY_ACCUMULATOR: begin
					pc_next = rel_tgt; // [RULE_03]
					two = 1'b1;
				end
				SUM_MEMORY_AND_ACCUMULATOR: {alu, dst, set_cdz} = {add8(fval, w_reg, 1'b0), 2'b11}; // [RULE_05]
				SUM_WITH_CARRY_IN: {alu, dst, set_cdz} = {add8(fval, w_reg, flg_reg.c), 2'b11}; // [RULE_06]
				IMMEDIATE_MINUS_ACCUMULATOR: {alu, wr_w, set_cdz} = {add8(k, ~w_reg, 1'b1), 2'b11}; // [RULE_13]
				MEMORY_MINUS_ACCUMULATOR: {alu, dst, set_cdz} = {add8(fval, ~w_reg, 1'b1), 2'b11}; // [RULE_13]
				MEMORY_MINUS_WITH_BORROW: {alu, dst, set_cdz} = {add8(fval, ~w_reg, flg_reg.c), 2'b11}; // [RULE_13]
				CONJUNCTION_IMMEDIATE: {res, wr_w, set_z} = {w_reg & k, 2'b11}; // [RULE_07]
				CONJUNCTION_MEMORY: {res, dst, set_z} = {w_reg & fval, 2'b11}; // [RULE_07]
				DISJUNCTION_IMMEDIATE: {res, wr_w, set_z} = {w_reg | k, 2'b11}; // [RULE_07]
				DISJUNCTION_MEMORY: {res, dst, set_z} = {w_reg | fval, 2'b11}; // [RULE_07]
				EXCLUSIVE_OR_IMMEDIATE: {res, wr_w, set_z} = {w_reg ^ k, 2'b11}; // [RULE_07]
				EXCLUSIVE_OR_MEMORY: {res, dst, set_z} = {w_reg ^ fval, 2'b11}; // [RULE_07]
				BIT_CLEAR_OP: {res, wr_f} = {fval & ~bitmask(bsel), 1'b1}; // [RULE_08]
				BIT_SET_OP: {res, wr_f} = {fval | bitmask(bsel), 1'b1}; // [RULE_08]
				SKIP_IF_BIT_LOW: skip = (fval & bitmask(bsel)) == 8'h00; // [RULE_09]
				SKIP_IF_BIT_HIGH: skip = (fval & bitmask(bsel)) != 8'h00; // [RULE_09]
				ZERO_MEMORY_BYTE: {res, wr_f, set_z} = {8'h00, 2'b11}; // [RULE_12]
				INVERT_MEMORY_BYTE: {res, dst, set_z} = {~fval, 2'b11}; // [RULE_12]
				DECREMENT_MEMORY: {res, dst, set_z} = {fval - 8'h01, 2'b11}; // [RULE_12]
				INCREMENT_MEMORY: {res, dst, set_z} = {fval + 8'h01, 2'b11}; // [RULE_12]
				DECREMENT_SKIP_ON_ZERO: begin
					res = fval - 8'h01; // [RULE_11]
					dst = 1'b1;
					skip = res == 8'h00;
				end
				INCREMENT_SKIP_ON_ZERO: begin
					res = fval + 8'h01; // [RULE_11]
					dst = 1'b1;
					skip = res == 8'h00;
				end
				ROTATE_LEFT_OP: {res, new_c, dst, set_c} = {fval[6:0], flg_reg.c, fval[7], 2'b11}; // [RULE_18]
				ROTATE_RIGHT_OP: {res, new_c, dst, set_c} = {flg_reg.c, fval, 2'b11}; // [RULE_18]
				LOAD_ACCUMULATOR_FROM_MEMORY: wr_w = 1'b1; // [RULE_19]
				LOAD_ACCUMULATOR_IMMEDIATE: {res, wr_w} = {k, 1'b1}; // [RULE_19]
				STORE_ACCUMULATOR_TO_MEMORY: {res, wr_f} = {w_reg, 1'b1}; // [RULE_19]
				WATCHDOG_KICK: kick = 1'b1; // [RULE_14]
				HALT_CORE: go_halt = 1'b1; // [RULE_16]
				SLEEP_CORE: go_sleep = 1'b1; // [RULE_17]
				INTERRUPT_RETURN: {pop, gie_set, two} = 3'b111; // [RULE_10]
				RETURN_WITH_IMMEDIATE: {res, wr_w, pop, two} = {k, 3'b111}; // [RULE_10]
				PLAIN_RETURN: {pop, two} = 2'b11; // [RULE_10]
				NO_OPERATION: ;
				default: ;
			endcase
		end
		if (set_cdz)
			res = alu.sum;
		if (dst) begin
			wr_w = !dsel; // [RULE_04]
			wr_f = dsel;
		end
		if (skip) begin
			pc_next = pc_reg + 11'h002; // [RULE_09] [RULE_11]
			two = 1'b1;
		end
		if (pop)
			pc_next = stk[sp_reg - 3'h1];
		if (take_irq) begin
			pc_next = IRQ_VEC;
			push_pc = pc_reg;
		end
		flg_next = flg_reg;
		if (set_cdz) begin
			flg_next.c = alu.c;
			flg_next.nibble_carry_flag = alu.dc;
		end
		if (set_c)
			flg_next.c = new_c;
		if (set_cdz || set_z || set_c)
			flg_next.z = res == 8'h00;
		if (kick)
			{flg_next.watchdog_expired_flag, flg_next.power_down_flag} = 2'b11;
		if (go_sleep)
			{flg_next.watchdog_expired_flag, flg_next.power_down_flag} = 2'b10; // [RULE_17]
	end

	// ====================
	// Sequencer and counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= ST_IDLE;
			pc_reg <= RESET_VEC;
		end else if (timeout) begin
			st_reg <= ST_IDLE;
			pc_reg <= RESET_VEC;
		end else begin
			unique case (st_reg)
				ST_IDLE: if (run) st_reg <= ST_EXEC;
				ST_EXEC: begin
					if (!run) begin
						st_reg <= ST_IDLE;
					end else begin
						pc_reg <= pc_next;
						if (take_irq || two)
							st_reg <= ST_FLUSH; // [RULE_03] [RULE_10]
						else if (go_halt)
							st_reg <= ST_HALT; // [RULE_16]
						else if (go_sleep)
							st_reg <= ST_SLEEP; // [RULE_17]
					end
				end
				ST_FLUSH: st_reg <= ST_EXEC;
				ST_HALT: if (irq_pend) st_reg <= ST_EXEC; // [RULE_16]
				ST_SLEEP: if (irq_ext) st_reg <= ST_EXEC; // [RULE_17]
			endcase
		end
	end

	// Stack wraps silently when overfilled, like a fixed hardware stack
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sp_reg <= 3'h0;
		else if (timeout)
			sp_reg <= 3'h0;
		else if (exec_ok && pop)
			sp_reg <= sp_reg - 3'h1;
		else if (st_reg == ST_EXEC && run && (push || take_irq))
			sp_reg <= sp_reg + 3'h1;
	end

	always_ff @(posedge pclk) begin
		if (st_reg == ST_EXEC && run && !timeout && (take_irq || push))
			stk[sp_reg] <= push_pc; // [RULE_10]
		if (exec_ok && wr_f)
			mem[fa] <= res; // [RULE_04]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w_reg <= 8'h00;
			flg_reg <= FLAGS_RST;
		end else begin
			if (exec_ok && wr_w)
				w_reg <= res; // [RULE_04]
			if (timeout)
				flg_reg.watchdog_expired_flag <= 1'b0;
			else if (exec_ok)
				flg_reg <= flg_next;
		end
	end

	// Counter is frozen in sleep since its clock source is stopped there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wdt_reg <= 16'h0000;
		else if ((exec_ok && kick) || timeout || !ctrl_reg[CTRL_WDTEN])
			wdt_reg <= 16'h0000; // [RULE_14]
		else if (st_reg != ST_SLEEP)
			wdt_reg <= wdt_reg + 16'h0001;
	end

	// ====================
	// APB slave: read data captured in setup, zero wait states
	logic        apb_wr, hit;
	logic [31:0] rdata;

	assign pready = psel & penable;
	assign apb_wr = psel & penable & pwrite;

	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr)
			A_CTRL: rdata = {28'h0, gie_reg, ctrl_reg};
			A_STAT: rdata = {24'h0, st_reg == ST_SLEEP, st_reg == ST_HALT, gie_reg, flg_reg};
			A_WREG: rdata = {24'h0, w_reg};
			A_PC: rdata = {21'h0, pc_reg};
			A_WDT: rdata = {16'h0, wdt_reg};
			A_MADDR: rdata = {25'h0, maddr_reg};
			A_MDATA: rdata = {24'h0, mem[maddr_reg]};
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : rdata;
			pslverr <= !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RST;
			maddr_reg <= 7'h00;
		end else if (apb_wr && paddr == A_CTRL) begin
			ctrl_reg <= pwdata[2:0];
		end else if (apb_wr && paddr == A_MADDR) begin
			maddr_reg <= pwdata[6:0];
		end
	end

	// Hardware set beats a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gie_reg <= 1'b0;
		else if (st_reg == ST_EXEC && run && !timeout && take_irq)
			gie_reg <= 1'b0;
		else if (exec_ok && gie_set)
			gie_reg <= 1'b1; // [RULE_10]
		else if (apb_wr && paddr == A_CTRL)
			gie_reg <= pwdata[CTRL_GIE];
	end

	// ====================
	// Assertions
	property p_add_imm;
		@(posedge pclk) disable iff (!presetn)
		exec_ok && !is_jump && op == SUM_IMMEDIATE_INTO_ACCUMULATOR |=> w_reg == $past(w_reg) + $past(k);
	endproperty
	a_add_imm: assert property (p_add_imm) else $error("immediate add result wrong"); // [RULE_02]

	property p_rel_jump;
		@(posedge pclk) disable iff (!presetn)
		exec_ok && !is_jump && op == RELATIVE_JUMP_BY_ACCUMULATOR |=> pc_reg == $past(rel_tgt) && st_reg == ST_FLUSH;
	endproperty
	a_rel_jump: assert property (p_rel_jump) else $error("relative jump target wrong"); // [RULE_03]

	property p_dest_w;
		@(posedge pclk) disable iff (!presetn)
		exec_ok && !is_jump && dst && !dsel |=> w_reg == $past(res);
	endproperty
	a_dest_w: assert property (p_dest_w) else $error("destination zero missed accumulator"); // [RULE_04]

	property p_logic_flags;
		@(posedge pclk) disable iff (!presetn)
		exec_ok && set_z |=> $stable(flg_reg.c) && $stable(flg_reg.nibble_carry_flag);
	endproperty
	a_logic_flags: assert property (p_logic_flags) else $error("logic op touched carry"); // [RULE_07]

	property p_bit_noflag;
		@(posedge pclk) disable iff (!presetn)
		exec_ok && !is_jump && (op == BIT_CLEAR_OP || op == BIT_SET_OP) |=> $stable(flg_reg);
	endproperty
	a_bit_noflag: assert property (p_bit_noflag) else $error("bit op changed flags"); // [RULE_08]

	property p_skip;
		@(posedge pclk) disable iff (!presetn)
		exec_ok && !is_jump && skip |=> st_reg == ST_FLUSH ##1 pc_reg == $past(pc_reg, 2) + 11'h002;
	endproperty
	a_skip: assert property (p_skip) else $error("skip did not pass one word"); // [RULE_09]

	property p_two_cycle;
		@(posedge pclk) disable iff (!presetn)
		st_reg == ST_FLUSH && !timeout |=> st_reg == ST_EXEC;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("flush lasted more than one cycle"); // [RULE_10]

	property p_kick;
		@(posedge pclk) disable iff (!presetn)
		exec_ok && !is_jump && op == WATCHDOG_KICK |=> wdt_reg == 16'h0000 && $stable(flg_reg.z);
	endproperty
	a_kick: assert property (p_kick) else $error("watchdog kick failed"); // [RULE_14]

	property p_halt;
		@(posedge pclk) disable iff (!presetn)
		st_reg == ST_HALT && !irq_pend && !timeout |=> $stable(pc_reg) && st_reg == ST_HALT;
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted"); // [RULE_16]

	property p_sleep;
		@(posedge pclk) disable iff (!presetn)
		st_reg == ST_SLEEP |-> osc_stop && !flg_reg.power_down_flag;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep state inconsistent"); // [RULE_17]
endmodule
`default_nettype wire

// ### rtl/mie_pkg.sv
// Shared constants, opcodes, states and carriers of the instruction execute unit
package mie_pkg;
	// ====================
	// Sizes and vectors
	localparam int          PC_W          = 11;
	localparam int          STACK_D       = 8;
	localparam int          MEM_D         = 128;
	localparam int          APB_AW        = 8;
	localparam int unsigned WDT_LIMIT_DEF = 65535;
	localparam logic [10:0] RESET_VEC     = 11'h000;
	localparam logic [10:0] IRQ_VEC       = 11'h004;
	localparam logic [3:0]  JUMP_PFX      = 4'hf;
	localparam int          JUMP_CALL_BIT = 11;

	// ====================
	// APB register map
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_WREG  = 8'h08;
	localparam logic [7:0] A_PC    = 8'h0c;
	localparam logic [7:0] A_WDT   = 8'h10;
	localparam logic [7:0] A_MADDR = 8'h14;
	localparam logic [7:0] A_MDATA = 8'h18;
	localparam int         CTRL_RUN   = 0;
	localparam int         CTRL_SIRQ  = 1;
	localparam int         CTRL_WDTEN = 2;
	localparam int         CTRL_GIE   = 3;
	localparam logic [2:0] CTRL_RST   = 3'h0;

	// ====================
	// Opcodes in bits 15:10; jumps use prefix 4'hf in bits 15:12
	typedef enum logic [5:0] {
		SUM_IMMEDIATE_INTO_ACCUMULATOR = 6'h00, RELATIVE_JUMP_BY_ACCUMULATOR, SUM_MEMORY_AND_ACCUMULATOR,
		SUM_WITH_CARRY_IN, CONJUNCTION_IMMEDIATE, CONJUNCTION_MEMORY, BIT_CLEAR_OP, BIT_SET_OP,
		SKIP_IF_BIT_LOW, SKIP_IF_BIT_HIGH, ZERO_MEMORY_BYTE, WATCHDOG_KICK, INVERT_MEMORY_BYTE,
		DECREMENT_MEMORY, DECREMENT_SKIP_ON_ZERO, HALT_CORE, INCREMENT_MEMORY, INCREMENT_SKIP_ON_ZERO,
		DISJUNCTION_IMMEDIATE, DISJUNCTION_MEMORY, LOAD_ACCUMULATOR_FROM_MEMORY, LOAD_ACCUMULATOR_IMMEDIATE,
		STORE_ACCUMULATOR_TO_MEMORY, NO_OPERATION, INTERRUPT_RETURN, RETURN_WITH_IMMEDIATE, PLAIN_RETURN,
		ROTATE_LEFT_OP, ROTATE_RIGHT_OP, SLEEP_CORE, IMMEDIATE_MINUS_ACCUMULATOR, MEMORY_MINUS_ACCUMULATOR,
		MEMORY_MINUS_WITH_BORROW, EXCLUSIVE_OR_IMMEDIATE, EXCLUSIVE_OR_MEMORY
	} mie_op_e;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_EXEC  = 5'h02,
		ST_FLUSH = 5'h04,
		ST_HALT  = 5'h08,
		ST_SLEEP = 5'h10
	} mie_state_e;

	typedef struct packed {
		logic watchdog_expired_flag;
		logic power_down_flag;
		logic z;
		logic nibble_carry_flag;
		logic c;
	} mie_flags_s;
	localparam mie_flags_s FLAGS_RST = 5'h18;

	typedef struct packed {
		logic       c;
		logic       dc;
		logic [7:0] sum;
	} mie_alu_s;
endpackage

// ### verification/mie_prog_rom.sv
// Program memory model: asynchronous word store that the bench fills
`timescale 1ns/100ps
`default_nettype none
module mie_prog_rom
	import mie_pkg::*;
(
	// Fetch port
	input  wire logic [PC_W-1:0] prog_addr,
	output logic      [15:0]     prog_data
);
	// ====================
	// Storage
	logic [15:0] mem [0:(1<<PC_W)-1];

	// Whole word answered in the same cycle; the core fetches without a wait state
	assign prog_data = mem[prog_addr];
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the instruction execute unit
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import mie_pkg::*;
;
	typedef struct packed {
		logic [7:0] w;
		logic [7:0] mm;
		logic       z;
		logic       dc;
		logic       c;
	} mie_exp_s;

	// ====================
	// Signals
	logic              pclk    = 1'b0;
	logic              presetn = 1'b0;
	logic              psel    = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite  = 1'b0;
	logic              irq_ext = 1'b0;
	logic [APB_AW-1:0] paddr   = '0;
	logic [31:0]       pwdata  = '0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              osc_stop;
	logic [PC_W-1:0]   prog_addr;
	logic [15:0]       prog_data;
	int                n_errors        = 0;
	int                samples_checked = 0;
	int                cyc             = 0;
	mie_op_e           ops [26] = '{SUM_IMMEDIATE_INTO_ACCUMULATOR, SUM_MEMORY_AND_ACCUMULATOR, SUM_WITH_CARRY_IN,
		CONJUNCTION_IMMEDIATE, CONJUNCTION_MEMORY, BIT_CLEAR_OP, BIT_SET_OP, SKIP_IF_BIT_LOW, SKIP_IF_BIT_HIGH,
		ZERO_MEMORY_BYTE, INVERT_MEMORY_BYTE, DECREMENT_MEMORY, DECREMENT_SKIP_ON_ZERO, INCREMENT_MEMORY,
		INCREMENT_SKIP_ON_ZERO, DISJUNCTION_IMMEDIATE, DISJUNCTION_MEMORY, LOAD_ACCUMULATOR_FROM_MEMORY,
		ROTATE_LEFT_OP, ROTATE_RIGHT_OP, IMMEDIATE_MINUS_ACCUMULATOR, MEMORY_MINUS_ACCUMULATOR,
		MEMORY_MINUS_WITH_BORROW, EXCLUSIVE_OR_IMMEDIATE, EXCLUSIVE_OR_MEMORY, NO_OPERATION};

	always #50 pclk = ~pclk;

	// Short watchdog limit; unused, since the bench never sets the watchdog enable bit
	mie_core #(.WDT_LIMIT(64)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prog_addr(prog_addr), .prog_data(prog_data), .irq_ext(irq_ext), .osc_stop(osc_stop));
	mie_prog_rom u_rom (.prog_addr(prog_addr), .prog_data(prog_data));

	// ====================
	// Checking and closing
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk_word(logic [31:0] got, logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(logic got, logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
		end
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			complete_run();
		end
	end

	// ====================
	// Bus and program helpers
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(logic [7:0] a, logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk_word(r, x);
	endtask

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Starts the core and polls until it halts or sleeps; a bounded poll, never a fixed delay
	task automatic run_wait();
		logic [31:0] s;
		logic        e;
		wr(A_CTRL, 32'h1);
		s = '0;
		for (int i = 0; i < 50 && s[7:6] == 2'b00; i++) apb(1'b0, A_STAT, 32'h0, s, e);
	endtask

	function automatic logic [15:0] ins(mie_op_e op, logic [9:0] lo);
		return {op, lo};
	endfunction

	function automatic logic is_skip(mie_op_e op);
		return op inside {SKIP_IF_BIT_LOW, SKIP_IF_BIT_HIGH, INCREMENT_SKIP_ON_ZERO, DECREMENT_SKIP_ON_ZERO};
	endfunction

	// Expected accumulator, memory byte and flags, from carry, nibble carry and zero all clear
	function automatic mie_exp_s exp_of(mie_op_e op, logic [7:0] a, logic [7:0] m, logic [9:0] lo);
		mie_exp_s   e;
		logic [7:0] x;
		logic [7:0] r;
		logic       imm;
		logic       res;
		logic       sk;
		imm = op inside {SUM_IMMEDIATE_INTO_ACCUMULATOR, CONJUNCTION_IMMEDIATE, DISJUNCTION_IMMEDIATE,
			EXCLUSIVE_OR_IMMEDIATE, IMMEDIATE_MINUS_ACCUMULATOR};
		x = imm ? lo[7:0] : m;
		e = '{w: a, mm: m, z: 1'b0, dc: 1'b0, c: 1'b0};
		r = 8'h00;
		res = 1'b1;
		sk = 1'b0;
		case (op)
			SUM_IMMEDIATE_INTO_ACCUMULATOR, SUM_MEMORY_AND_ACCUMULATOR, SUM_WITH_CARRY_IN: begin
				{e.c, r} = {1'b0, x} + {1'b0, a};
				e.dc = ({1'b0, x[3:0]} + {1'b0, a[3:0]}) > 5'h0f;
			end
			IMMEDIATE_MINUS_ACCUMULATOR, MEMORY_MINUS_ACCUMULATOR: begin
				r = x - a;
				e.c = x >= a;
				e.dc = x[3:0] >= a[3:0];
			end
			MEMORY_MINUS_WITH_BORROW: begin
				r = x - a - 8'h01;
				e.c = x > a;
				e.dc = x[3:0] > a[3:0];
			end
			CONJUNCTION_IMMEDIATE, CONJUNCTION_MEMORY: r = x & a;
			DISJUNCTION_IMMEDIATE, DISJUNCTION_MEMORY: r = x | a;
			EXCLUSIVE_OR_IMMEDIATE, EXCLUSIVE_OR_MEMORY: r = x ^ a;
			INCREMENT_MEMORY: r = m + 8'h01;
			DECREMENT_MEMORY: r = m - 8'h01;
			INVERT_MEMORY_BYTE: r = ~m;
			ROTATE_LEFT_OP: {e.c, r} = {m, 1'b0};
			ROTATE_RIGHT_OP: {r, e.c} = {1'b0, m};
			default: res = 1'b0;
		endcase
		if (res) begin
			e.z = r == 8'h00;
			if (imm || !lo[7]) e.w = r;
			else e.mm = r;
		end
		case (op)
			ZERO_MEMORY_BYTE: begin
				e.mm = 8'h00;
				e.z = 1'b1;
			end
			BIT_CLEAR_OP: e.mm[lo[9:7]] = 1'b0;
			BIT_SET_OP: e.mm[lo[9:7]] = 1'b1;
			LOAD_ACCUMULATOR_FROM_MEMORY: e.w = m;
			SKIP_IF_BIT_LOW: sk = !m[lo[9:7]];
			SKIP_IF_BIT_HIGH: sk = m[lo[9:7]];
			INCREMENT_SKIP_ON_ZERO: e.mm = m + 8'h01;
			DECREMENT_SKIP_ON_ZERO: e.mm = m - 8'h01;
			default: ;
		endcase
		if (op inside {INCREMENT_SKIP_ON_ZERO, DECREMENT_SKIP_ON_ZERO}) sk = e.mm == 8'h00;
		if (is_skip(op)) e.w = sk ? a : 8'h55;
		return e;
	endfunction

	// ====================
	// Main sequence
	initial begin
		logic [7:0]  a;
		logic [7:0]  m;
		logic [9:0]  lo;
		logic [31:0] r;
		logic        er;
		mie_exp_s    e;
		void'($urandom(32'hbd53));
		for (int i = 0; i < (1 << PC_W); i++) u_rom.mem[i] = ins(NO_OPERATION, 10'h0);
		do_reset();
		rd_chk(A_STAT, 32'h18);
		rd_chk(A_PC, 32'h0);
		rd_chk(A_WREG, 32'h0);
		apb(1'b0, 8'h1c, 32'h0, r, er);
		chk_pin(er, 1'b1);
		// Every data operation from boundary values first, then random ones
		for (int t = 0; t < 3; t++) foreach (ops[i]) begin
			a = (t == 0) ? 8'h01 : 8'($urandom);
			m = (t == 0) ? 8'hff : (t == 1) ? 8'h01 : 8'($urandom);
			lo = 10'($urandom);
			if (ops[i] inside {INCREMENT_SKIP_ON_ZERO, DECREMENT_SKIP_ON_ZERO}) lo[7] = 1'b1;
			e = exp_of(ops[i], a, m, lo);
			do_reset();
			u_rom.mem[0] = ins(LOAD_ACCUMULATOR_IMMEDIATE, {2'b00, m});
			u_rom.mem[1] = ins(STORE_ACCUMULATOR_TO_MEMORY, {3'b000, lo[6:0]});
			u_rom.mem[2] = ins(LOAD_ACCUMULATOR_IMMEDIATE, {2'b00, a});
			u_rom.mem[3] = ins(ops[i], lo);
			u_rom.mem[4] = is_skip(ops[i]) ? ins(LOAD_ACCUMULATOR_IMMEDIATE, 10'h055) : ins(NO_OPERATION, 10'h0);
			u_rom.mem[5] = ins(HALT_CORE, 10'h0);
			run_wait();
			rd_chk(A_PC, 32'h6);
			rd_chk(A_WREG, {24'h0, e.w});
			wr(A_MADDR, {25'h0, lo[6:0]});
			rd_chk(A_MDATA, {24'h0, e.mm});
			rd_chk(A_STAT, {24'h0, 5'b01011, e.z, e.dc, e.c});
		end
		// Relative jumps both ways, call with literal return and with interrupt return
		do_reset();
		u_rom.mem[0] = ins(LOAD_ACCUMULATOR_IMMEDIATE, 10'h003);
		u_rom.mem[1] = ins(RELATIVE_JUMP_BY_ACCUMULATOR, 10'h0);
		for (int i = 2; i < 5; i++) u_rom.mem[i] = ins(HALT_CORE, 10'h0);
		u_rom.mem[5] = {JUMP_PFX, 1'b1, 11'h040};
		u_rom.mem[6] = {JUMP_PFX, 1'b1, 11'h050};
		u_rom.mem[7] = ins(RELATIVE_JUMP_BY_ACCUMULATOR, 10'h0);
		u_rom.mem[11'h040] = ins(RETURN_WITH_IMMEDIATE, 10'h080);
		u_rom.mem[11'h050] = ins(INTERRUPT_RETURN, 10'h0);
		u_rom.mem[11'h788] = ins(HALT_CORE, 10'h0);
		run_wait();
		rd_chk(A_PC, 32'h789);
		rd_chk(A_WREG, 32'h80);
		rd_chk(A_STAT, 32'h78);
		// Sleep, wake, halt, wake, watchdog kick
		do_reset();
		u_rom.mem[0] = ins(SLEEP_CORE, 10'h0);
		u_rom.mem[1] = ins(HALT_CORE, 10'h0);
		u_rom.mem[2] = ins(WATCHDOG_KICK, 10'h0);
		u_rom.mem[3] = ins(HALT_CORE, 10'h0);
		run_wait();
		chk_pin(osc_stop, 1'b1);
		rd_chk(A_STAT, 32'h90);
		irq_ext <= 1'b1;
		for (int i = 0; i < 20 && osc_stop !== 1'b0; i++) @(posedge pclk);
		irq_ext <= 1'b0;
		repeat (10) @(posedge pclk);
		rd_chk(A_PC, 32'h2);
		rd_chk(A_PC, 32'h2);
		@(posedge pclk);
		irq_ext <= 1'b1;
		repeat (2) @(posedge pclk);
		irq_ext <= 1'b0;
		repeat (10) @(posedge pclk);
		rd_chk(A_PC, 32'h4);
		rd_chk(A_STAT, 32'h58);
		rd_chk(A_WDT, 32'h0);
		// Interrupt taken out of halt: vector entry pushes, clears global enable
		do_reset();
		u_rom.mem[0] = ins(HALT_CORE, 10'h0);
		u_rom.mem[1] = ins(HALT_CORE, 10'h0);
		u_rom.mem[IRQ_VEC] = ins(HALT_CORE, 10'h0);
		wr(A_CTRL, 32'h9);
		repeat (10) @(posedge pclk);
		rd_chk(A_PC, 32'h1);
		irq_ext <= 1'b1;
		repeat (2) @(posedge pclk);
		irq_ext <= 1'b0;
		repeat (10) @(posedge pclk);
		rd_chk(A_PC, 32'h5);
		rd_chk(A_STAT, 32'h58);
		complete_run();
	end
endmodule
`default_nettype wire
